// ### logic/emisg_cfg.svh
// Purpose: Offsets, field positions, reset values and lengths of the strobe generator
// Assumes: Included by the bare name wherever these constants are needed
// Notes:   Phase lengths are stored as length minus one, two bits per phase
`ifndef EMISG_CFG_SVH
`define EMISG_CFG_SVH

`define EMISG_OFF_PHASE   8'h00
`define EMISG_OFF_STROBE  8'h04
`define EMISG_OFF_CTRL    8'h08
`define EMISG_OFF_STATUS  8'h0c
`define EMISG_OFF_COUNT   8'h10

`define EMISG_PLEN_W      2
`define EMISG_PHASE_W     12
`define EMISG_PHASE_RST   12'hfff
`define EMISG_STROBE_RST  32'h121e1e1f

`define EMISG_S1_POS      0
`define EMISG_S2_POS      8
`define EMISG_S3_POS      16
`define EMISG_S4_POS      24

`define EMISG_LOCK_BIT    0
`define EMISG_ST_BUSY     0
`define EMISG_ST_LOCK     1
`define EMISG_ST_PH_POS   4

`endif

// ### logic/emisg_delay_cmp.sv
// Purpose: Start compare for one delay-configurable strobe
// Assumes: Elapsed count starts at zero in the first period of T2
// Notes:   Output is an active-high level, registered by the caller
`timescale 1ns/1ps
module emisg_delay_cmp #(
  parameter int SDW = 5,
  parameter int ELW = 6
) (
  input  wire logic [ELW-1:0] elapsed,
  input  wire logic [SDW-1:0] delay,
  input  wire logic           window,
  output logic                active
);

  // Zero delay never asserts; a late start simply never meets the window
  always_comb begin
    active = window && (delay != '0) && ({{(ELW-SDW){1'b0}}, delay} <= elapsed);
  end

endmodule

// ### logic/emisg_pkg.sv
// Purpose: Types shared by the strobe generator modules
// Assumes: Nothing beyond the standard language
// Notes:   Phase E is the padding period that evens out an odd total
package emisg_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_T1,
    PH_T2,
    PH_T3,
    PH_T4,
    PH_T5,
    PH_T6,
    PH_E
  } emisg_phase_t;

endpackage

// ### logic/emisg_sync2.sv
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Input is a slow level from outside the clock domain
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
module emisg_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ### logic/emisg_top.sv
// Purpose: Strobe and control-pin generator for a multiplexed memory bus
// Assumes: One hclk cycle is one half-clock unit; AHB-Lite register slave
// Notes:   Configuration freezes once software sets the lock bit
//
// What this block does
// [R1] In T1 and T2 write flag pin is low for writes, else high.
// [R2] From T3 to T6 write flag pin carries data bit 0.
// [R3] In T1 and T2 refresh flag pin is low for refresh addresses.
// [R4] From T3 to T6 refresh flag pin carries data bit 1.
// [R5] Read strobe is low through T4 and T5 of a read cycle only.
// [R6] Read data is captured as the read strobe rises.
// [R7] Memory may drop read data right after the read strobe rises.
// [R8] Longer T4, T5 or wait states lengthen the read strobe.
// [R9] Five general strobes: one fixed, four with configurable timing.
// [R10] Fixed strobe runs from start of T2 to end of T5.
// [R11] Length strobe starts at T2 and lasts 0 to 31 half-clocks.
// [R12] Length strobe ends no later than the end of T6.
// [R13] Waits do not stretch the length strobe's counted duration.
// [R14] Length strobe set to zero stays high the whole cycle.
// [R15] Delayed strobes start 1 to 31 half-clocks after T2, end at T5.
// [R16] A delayed start at or past T5 end leaves the strobe high.
// [R17] A delayed strobe set to zero never asserts.
// [R18] Cycle is T1 to T6 plus waits, each phase 1 to 4 half-clocks.
// [R19] Half-clock unit is exactly half a processor clock period.
// [R20] After reset every phase is four half-clocks long.
// [R21] Odd totals get one extra period so T1 starts on a rising clock.
// [R22] T4 extends for as long as wait is requested.
// [R23] Timing settings are loaded after reset and then held unchanged; here they stay writable until the lock bit is set.
// [R24] Internal accesses keep all external strobes inactive.
`timescale 1ns/1ps
`include "emisg_cfg.svh"
module emisg_top
  import emisg_pkg::*;
#(
  parameter int SDW = 5,
  parameter int ELW = 6
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        cyc_req,
  input  wire logic        cyc_internal,
  input  wire logic        cyc_write,
  input  wire logic        cyc_refresh,
  input  wire logic [31:2] cyc_addr,
  input  wire logic [31:0] cyc_wdata,
  output logic             cyc_ack,
  output logic             cyc_done,
  output logic      [31:0] cyc_rdata,
  output logic             processor_clock_out,
  input  wire logic [31:2] muxed_addr_data_in,
  output logic      [31:2] muxed_addr_data_out,
  output logic             muxed_addr_data_oe,
  input  wire logic        write_flag_data0_in,
  output logic             write_flag_data0_out,
  output logic             write_flag_data0_oe,
  input  wire logic        refresh_flag_data1_in,
  output logic             refresh_flag_data1_out,
  output logic             refresh_flag_data1_oe,
  input  wire logic        mem_wait,
  output logic             read_strobe_n,
  output logic             fixed_strobe_n,
  output logic             length_strobe_n,
  output logic             delayed_strobe_a_n,
  output logic             delayed_strobe_b_n,
  output logic             delayed_strobe_c_n
);

  // Register slave state
  logic [`EMISG_PHASE_W-1:0] phase_cfg_reg, phase_cfg_next;
  logic [31:0]               strobe_cfg_reg, strobe_cfg_next;
  logic                      lock_reg, lock_next;
  logic                      wpend_reg, wpend_next;
  logic [7:0]                waddr_reg, waddr_next;
  logic [31:0]               hrdata_next;
  logic [31:0]               count_reg, count_next;

  // Sequencer state
  emisg_phase_t              phase_reg, phase_next;
  logic [2:0]                cnt_reg, cnt_next;
  logic [ELW-1:0]            el_reg, el_next;
  logic                      pclk_reg, pclk_next;
  logic                      wr_reg, wr_next;
  logic                      rf_reg, rf_next;
  logic [31:2]               addr_reg, addr_next;
  logic [31:0]               wdata_reg, wdata_next;
  logic [31:0]               cap_reg, cap_next;
  logic [31:0]               rdata_next;
  logic                      ack_next, done_next;
  logic                      wait_s;
  logic                      odd_total;
  logic [4:0]                total_len;
  logic [SDW-1:0]            len1, dly2, dly3, dly4;
  logic                      win25, win26;
  logic [2:0]                dly_act;

  // Pin next values
  logic [31:2]               mad_out_next;
  logic                      mad_oe_next, wf_out_next, rf_out_next, flag_oe_next;
  logic                      rd_n_next, fix_n_next, len_n_next;

  emisg_sync2 #(.W(1)) u_wait_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (mem_wait),
    .q     (wait_s)
  );

  assign len1 = strobe_cfg_reg[`EMISG_S1_POS +: SDW];
  assign dly2 = strobe_cfg_reg[`EMISG_S2_POS +: SDW];
  assign dly3 = strobe_cfg_reg[`EMISG_S3_POS +: SDW];
  assign dly4 = strobe_cfg_reg[`EMISG_S4_POS +: SDW];

  function automatic logic [2:0] plen(input logic [`EMISG_PHASE_W-1:0] cfg, input int idx);
    plen = {1'b0, cfg[idx*`EMISG_PLEN_W +: `EMISG_PLEN_W]} + 3'h1;
  endfunction

  // [R21] Odd total detection
  always_comb begin
    total_len = 5'h00;
    for (int i = 0; i < 6; i++) begin
      total_len = total_len + {2'b00, plen(phase_cfg_reg, i)};
    end
    odd_total = total_len[0];
  end

  // Bus slave: writes land in the data phase, configuration reads are answered from next values
  always_comb begin
    phase_cfg_next  = phase_cfg_reg;
    strobe_cfg_next = strobe_cfg_reg;
    lock_next       = lock_reg;
    wpend_next      = hsel && htrans[1] && hready && hwrite;
    waddr_next      = haddr[7:0];
    hrdata_next     = hrdata;
    // [R23] Frozen after lock
    if (wpend_reg && !lock_reg) begin
      case (waddr_reg)
        `EMISG_OFF_PHASE:  phase_cfg_next  = hwdata[`EMISG_PHASE_W-1:0];
        `EMISG_OFF_STROBE: strobe_cfg_next = hwdata & 32'h1f1f1f1f;
        `EMISG_OFF_CTRL:   lock_next       = hwdata[`EMISG_LOCK_BIT];
        default:           lock_next       = lock_reg;
      endcase
    end
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        `EMISG_OFF_PHASE:  hrdata_next = {20'h00000, phase_cfg_next};
        `EMISG_OFF_STROBE: hrdata_next = strobe_cfg_next;
        `EMISG_OFF_CTRL:   hrdata_next = {31'h00000000, lock_next};
        `EMISG_OFF_STATUS: begin
          hrdata_next = 32'h00000000;
          hrdata_next[`EMISG_ST_BUSY] = (phase_reg != PH_IDLE);
          hrdata_next[`EMISG_ST_LOCK] = lock_reg;
          hrdata_next[`EMISG_ST_PH_POS +: 3] = phase_reg;
        end
        `EMISG_OFF_COUNT:  hrdata_next = count_reg;
        default:           hrdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // [R20] Every phase four periods long
      phase_cfg_reg  <= `EMISG_PHASE_RST;
      strobe_cfg_reg <= `EMISG_STROBE_RST;
      lock_reg       <= 1'b0;
      wpend_reg      <= 1'b0;
      waddr_reg      <= 8'h00;
      hrdata         <= 32'h00000000;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
    end else begin
      phase_cfg_reg  <= phase_cfg_next;
      strobe_cfg_reg <= strobe_cfg_next;
      lock_reg       <= lock_next;
      wpend_reg      <= wpend_next;
      waddr_reg      <= waddr_next;
      hrdata         <= hrdata_next;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
    end
  end

  function automatic emisg_phase_t after(input emisg_phase_t p);
    case (p)
      PH_T1:   after = PH_T2;
      PH_T2:   after = PH_T3;
      PH_T3:   after = PH_T4;
      PH_T4:   after = PH_T5;
      PH_T5:   after = PH_T6;
      default: after = PH_IDLE;
    endcase
  endfunction

  // Sequencer and pin next values
  always_comb begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    el_next    = el_reg;
    // [R19] One hclk cycle per half-clock unit
    pclk_next  = ~pclk_reg;
    wr_next    = wr_reg;
    rf_next    = rf_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    cap_next   = cap_reg;
    rdata_next = cyc_rdata;
    count_next = count_reg;
    ack_next   = 1'b0;
    done_next  = 1'b0;
    case (phase_reg)
      PH_IDLE: begin
        if (cyc_req && cyc_internal) begin
          // [R24] Internal access shows address and write flag; refresh flag stays high
          ack_next  = 1'b1;
          done_next = 1'b1;
          addr_next = cyc_addr;
          wr_next   = cyc_write;
          rf_next   = 1'b0;
        end else if (cyc_req && !pclk_reg) begin
          // [R21] T1 starts with a rising clock
          phase_next = PH_T1;
          cnt_next   = plen(phase_cfg_reg, 0) - 3'h1;
          ack_next   = 1'b1;
          addr_next  = cyc_addr;
          wr_next    = cyc_write;
          rf_next    = cyc_refresh;
          wdata_next = cyc_wdata;
        end
      end
      PH_T4: begin
        // [R22] Wait holds T4
        if (cnt_reg != 3'h0) begin
          cnt_next = cnt_reg - 3'h1;
        end else if (!wait_s) begin
          phase_next = PH_T5;
          cnt_next   = plen(phase_cfg_reg, 4) - 3'h1;
        end
      end
      PH_T6: begin
        if (cnt_reg != 3'h0) begin
          cnt_next = cnt_reg - 3'h1;
        end else if (odd_total) begin
          phase_next = PH_E;
        end else begin
          phase_next = PH_IDLE;
          done_next  = 1'b1;
        end
      end
      PH_E: begin
        phase_next = PH_IDLE;
        done_next  = 1'b1;
      end
      default: begin
        // [R18] Per-phase lengths
        if (cnt_reg != 3'h0) begin
          cnt_next = cnt_reg - 3'h1;
        end else begin
          phase_next = after(phase_reg);
          cnt_next   = plen(phase_cfg_reg, int'(phase_reg)) - 3'h1;
        end
      end
    endcase
    // [R13] Elapsed time runs on through waits
    if (phase_reg == PH_T1 && phase_next == PH_T2) begin
      el_next = '0;
    end else if (el_reg != '1) begin
      el_next = el_reg + 1'b1;
    end
    if (done_next && phase_reg != PH_IDLE) begin
      count_next = count_reg + 32'h00000001;
      rdata_next = cap_reg;
    end
    win25 = (phase_next == PH_T2) || (phase_next == PH_T3) ||
            (phase_next == PH_T4) || (phase_next == PH_T5);
    win26 = win25 || (phase_next == PH_T6);
    // [R5] Low in T4 and T5 of reads; [R8] stretches with the phases
    rd_n_next  = !(!wr_next && ((phase_next == PH_T4) || (phase_next == PH_T5)));
    // [R9] [R10] Fixed strobe window
    fix_n_next = !win25;
    // [R11] Counted duration; [R12] cut at T6 end; [R14] zero stays high
    len_n_next = !(win26 && (len1 != '0) && ({{(ELW-SDW){1'b0}}, len1} > el_next));
    // [R6] Capture at rising read strobe
    if (!read_strobe_n && rd_n_next) begin
      cap_next = {muxed_addr_data_in, refresh_flag_data1_in, write_flag_data0_in};
    end
    // [R1] [R3] Flags in address phases; [R2] [R4] data bits afterwards
    if (phase_next == PH_IDLE || phase_next == PH_T1 || phase_next == PH_T2) begin
      mad_out_next = addr_next;
      mad_oe_next  = 1'b1;
      wf_out_next  = !wr_next;
      rf_out_next  = !rf_next;
      flag_oe_next = 1'b1;
    end else begin
      mad_out_next = wdata_next[31:2];
      mad_oe_next  = wr_next;
      wf_out_next  = wdata_next[0];
      rf_out_next  = wdata_next[1];
      flag_oe_next = wr_next;
    end
  end

  // [R15] [R16] [R17] Three delayed strobes
  emisg_delay_cmp #(.SDW(SDW), .ELW(ELW)) u_dly_a (
    .elapsed (el_next), .delay (dly2), .window (win25), .active (dly_act[0])
  );
  emisg_delay_cmp #(.SDW(SDW), .ELW(ELW)) u_dly_b (
    .elapsed (el_next), .delay (dly3), .window (win25), .active (dly_act[1])
  );
  emisg_delay_cmp #(.SDW(SDW), .ELW(ELW)) u_dly_c (
    .elapsed (el_next), .delay (dly4), .window (win25), .active (dly_act[2])
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= PH_IDLE;
      cnt_reg <= 3'h0;
      el_reg <= '0;
      pclk_reg <= 1'b0;
      wr_reg <= 1'b0;
      rf_reg <= 1'b0;
      addr_reg <= 30'h00000000;
      wdata_reg <= 32'h00000000;
      cap_reg <= 32'h00000000;
      cyc_rdata <= 32'h00000000;
      count_reg <= 32'h00000000;
      cyc_ack <= 1'b0;
      cyc_done <= 1'b0;
      muxed_addr_data_out <= 30'h00000000;
      muxed_addr_data_oe <= 1'b0;
      write_flag_data0_out <= 1'b1;
      write_flag_data0_oe <= 1'b0;
      refresh_flag_data1_out <= 1'b1;
      refresh_flag_data1_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      fixed_strobe_n <= 1'b1;
      length_strobe_n <= 1'b1;
      delayed_strobe_a_n <= 1'b1;
      delayed_strobe_b_n <= 1'b1;
      delayed_strobe_c_n <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      el_reg <= el_next;
      pclk_reg <= pclk_next;
      wr_reg <= wr_next;
      rf_reg <= rf_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      cap_reg <= cap_next;
      cyc_rdata <= rdata_next;
      count_reg <= count_next;
      cyc_ack <= ack_next;
      cyc_done <= done_next;
      muxed_addr_data_out <= mad_out_next;
      muxed_addr_data_oe <= mad_oe_next;
      write_flag_data0_out <= wf_out_next;
      write_flag_data0_oe <= flag_oe_next;
      refresh_flag_data1_out <= rf_out_next;
      refresh_flag_data1_oe <= flag_oe_next;
      read_strobe_n <= rd_n_next;
      fixed_strobe_n <= fix_n_next;
      length_strobe_n <= len_n_next;
      delayed_strobe_a_n <= !dly_act[0];
      delayed_strobe_b_n <= !dly_act[1];
      delayed_strobe_c_n <= !dly_act[2];
    end
  end

  assign processor_clock_out = pclk_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_wflag_addr_phase: assert property ( // [R1]
    (phase_reg == PH_T1 || phase_reg == PH_T2) |-> write_flag_data0_out == !wr_reg
  ) else $error("write flag wrong in address phase");
  chk_rflag_addr_phase: assert property ( // [R3]
    (phase_reg == PH_T1 || phase_reg == PH_T2) |-> refresh_flag_data1_out == !rf_reg
  ) else $error("refresh flag wrong in address phase");
  chk_wdata_bits_low: assert property ( // [R2]
    (phase_reg == PH_T3 && wr_reg) |-> write_flag_data0_oe &&
      write_flag_data0_out == wdata_reg[0] && refresh_flag_data1_out == wdata_reg[1]
  ) else $error("low data bits not driven in write");
  chk_read_in_fixed: assert property ( // [R5]
    !read_strobe_n |-> !fixed_strobe_n && !wr_reg && (phase_reg inside {PH_T4, PH_T5})
  ) else $error("read strobe outside T4 and T5");
  chk_capture_edge: assert property ( // [R6]
    ($rose(read_strobe_n)) |-> cap_reg == {$past(muxed_addr_data_in),
      $past(refresh_flag_data1_in), $past(write_flag_data0_in)}
  ) else $error("read data not captured at strobe rise");
  chk_fixed_lead: assert property ( // [R10]
    $fell(fixed_strobe_n) |-> $past(phase_reg) == PH_T1 && phase_reg == PH_T2
  ) else $error("fixed strobe did not start at T2");
  chk_len_end: assert property ( // [R12]
    (phase_reg inside {PH_IDLE, PH_T1, PH_E}) |-> length_strobe_n
  ) else $error("length strobe active outside T2 to T6");
  chk_len_zero: assert property ( // [R14]
    (len1 == '0) |-> length_strobe_n
  ) else $error("zero length strobe went low");
  chk_dly_window: assert property ( // [R15]
    !delayed_strobe_a_n |-> (phase_reg inside {PH_T2, PH_T3, PH_T4, PH_T5}) &&
      dly2 != '0 && el_reg >= ELW'(dly2)
  ) else $error("delayed strobe outside its window");
  chk_wait_hold: assert property ( // [R22]
    (phase_reg == PH_T4 && cnt_reg == 3'h0 && wait_s) |=> phase_reg == PH_T4
  ) else $error("T4 not extended by wait");
  chk_even_start: assert property ( // [R21]
    (phase_reg == PH_T1 && $past(phase_reg) == PH_IDLE) |-> pclk_reg ##1 !pclk_reg
  ) else $error("cycle did not start on rising clock");
  chk_pad_odd: assert property ( // [R21]
    (phase_reg == PH_E) |-> odd_total ##1 phase_reg == PH_IDLE
  ) else $error("padding period misused");
  chk_internal_quiet: assert property ( // [R24]
    (phase_reg == PH_IDLE) |-> read_strobe_n && fixed_strobe_n && delayed_strobe_b_n &&
      delayed_strobe_c_n
  ) else $error("strobe active during idle or internal access");

  cov_read_cycle: cover property ($rose(read_strobe_n) ##[1:20] cyc_done);
  cov_write_cycle: cover property (phase_reg == PH_T3 && wr_reg);
  cov_wait_ext: cover property (phase_reg == PH_T4 && cnt_reg == 3'h0 && wait_s);
  cov_pad_period: cover property (phase_reg == PH_E);

endmodule

// ### tb/emisg_mem_model.sv
// Purpose: External memory model facing the strobe generator
// Assumes: Pin levels are resolved here from every driver's enable
// Notes:   Released data lines show the read word while the read strobe is low, else its inverse
`timescale 1ns/1ps
module emisg_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        read_strobe_n,
  input  wire logic        fixed_strobe_n,
  input  wire logic [31:2] bus_out,
  input  wire logic        bus_oe,
  input  wire logic        f0_out,
  input  wire logic        f0_oe,
  input  wire logic        f1_out,
  input  wire logic        f1_oe,
  input  wire logic [31:0] rval,
  input  wire logic [3:0]  wait_n,
  output logic      [31:0] pins,
  output logic             mem_wait
);
  logic [31:0] drv;
  logic [4:0]  wcnt;
  logic        f_prev;
  // Data dropped once the read strobe rises
  assign drv = read_strobe_n ? ~rval : rval;
  // Low data bits ride on the flag pins
  assign pins[31:2] = bus_oe ? bus_out : drv[31:2];
  assign pins[1] = f1_oe ? f1_out : drv[1];
  assign pins[0] = f0_oe ? f0_out : drv[0];
  // Wait raised as the fixed strobe falls, so even a short T4 sees it
  assign mem_wait = (wcnt != 5'h00) || (f_prev && !fixed_strobe_n && wait_n != 4'h0);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wcnt   <= 5'h00;
      f_prev <= 1'b1;
    end else begin
      f_prev <= fixed_strobe_n;
      if (f_prev && !fixed_strobe_n && wait_n != 4'h0)
        wcnt <= {1'b0, wait_n} + 5'h0a;
      else if (wcnt != 5'h00)
        wcnt <= wcnt - 5'h01;
    end
  end
endmodule

// ### tb/test_emi_strobe_generator.sv
// Purpose: Self-checking bench for the strobe generator
// Assumes: Random configurations, then lock; memory model on the pins
// Notes:   Strobe widths are counted per cycle and compared to phase lengths
`timescale 1ns/1ps
`include "emisg_cfg.svh"
module test_emi_strobe_generator;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pclk, run;
  logic [31:0] haddr, hwdata, hrdata, cyc_wdata, cyc_rdata, pins, rval, q, cfg_st;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        cyc_req, cyc_internal, cyc_write, cyc_refresh, cyc_ack, cyc_done;
  logic [31:2] cyc_addr, bus_out;
  logic        bus_oe, f0_out, f0_oe, f1_out, f1_oe, mem_wait, act, fprev, pcp, ew, er;
  logic        rd_n, fx_n, ln_n, da_n, db_n, dc_n;
  logic [3:0]  wait_n;
  logic [11:0] cfg_ph;
  int          n_fail, checks_done, seed, tmo, ncyc, n_ext, cnt[6];

  emisg_top u_emisg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cyc_req(cyc_req),
    .cyc_internal(cyc_internal), .cyc_write(cyc_write), .cyc_refresh(cyc_refresh),
    .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .cyc_ack(cyc_ack), .cyc_done(cyc_done),
    .cyc_rdata(cyc_rdata), .processor_clock_out(pclk), .muxed_addr_data_in(pins[31:2]),
    .muxed_addr_data_out(bus_out), .muxed_addr_data_oe(bus_oe),
    .write_flag_data0_in(pins[0]), .write_flag_data0_out(f0_out),
    .write_flag_data0_oe(f0_oe), .refresh_flag_data1_in(pins[1]),
    .refresh_flag_data1_out(f1_out), .refresh_flag_data1_oe(f1_oe), .mem_wait(mem_wait),
    .read_strobe_n(rd_n), .fixed_strobe_n(fx_n), .length_strobe_n(ln_n),
    .delayed_strobe_a_n(da_n), .delayed_strobe_b_n(db_n), .delayed_strobe_c_n(dc_n));

  emisg_mem_model u_emisg_mem_model (.hclk(hclk), .hresetn(hresetn), .read_strobe_n(rd_n),
    .fixed_strobe_n(fx_n), .bus_out(bus_out), .bus_oe(bus_oe), .f0_out(f0_out),
    .f0_oe(f0_oe), .f1_out(f1_out), .f1_oe(f1_oe), .rval(rval), .wait_n(wait_n),
    .pins(pins), .mem_wait(mem_wait));

  assign hready = hreadyout;
  initial hclk = 1'b0;
  always #2 hclk = ~hclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task final_report;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task rd_chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk("register", e, q);
  endtask

  function int plen(int k);
    return cfg_ph[2*k +: 2] + 1;
  endfunction
  function int exp_dly(int d, int f);
    return (d == 0 || d >= f) ? 0 : f - d;
  endfunction
  function int exp_len(int n, int lim);
    return (n < lim) ? n : lim;
  endfunction

  task cyc(input logic w, input logic rf, input logic in_, input logic [3:0] wn);
    int s, wt, f;
    @(posedge hclk);
    cyc_req <= 1'b1; cyc_write <= w; cyc_refresh <= rf; cyc_internal <= in_;
    cyc_addr <= 30'($random(seed)); cyc_wdata <= $random(seed);
    rval <= $random(seed); wait_n <= wn;
    ew = w; er = rf;
    do @(posedge hclk); while (cyc_ack !== 1'b1);
    cyc_req <= 1'b0;
    while (cyc_done !== 1'b1) @(posedge hclk);
    @(posedge hclk);
    f = cnt[1];
    s = plen(0) + plen(1) + plen(2) + plen(3) + plen(4) + plen(5);
    wt = f - (plen(1) + plen(2) + plen(3) + plen(4));
    if (in_) begin
      chk("internal strobes", 32'h3f, {26'h0, rd_n, fx_n, ln_n, da_n, db_n, dc_n});
    end else begin
      n_ext++;
      if (wn == 4'h0) begin
        chk("wait extension", 0, wt);
        chk("cycle length", s + s % 2, ncyc);
      end else begin
        chk("wait extension seen", 1, wt > 0);
      end
      chk("read strobe", w ? 0 : plen(3) + plen(4) + wt, cnt[0]);
      chk("length strobe", exp_len(cfg_st[4:0], f + plen(5)), cnt[2]);
      for (int k = 0; k < 3; k++) begin
        chk("delayed strobe", exp_dly(cfg_st[8+8*k +: 5], f), cnt[3+k]);
      end
      if (!w) chk("read data", rval, cyc_rdata);
    end
  endtask

  // Per-cycle strobe counter and pin watcher
  always @(posedge hclk) begin
    if (run) chk("clock toggle", {31'h0, !pcp}, pclk);
    pcp = pclk;
    tmo++;
    if (tmo == 40000) begin
      n_fail++;
      final_report;
    end
    if (cyc_ack === 1'b1) begin
      act = 1'b1;
      ncyc = 0;
      foreach (cnt[i]) cnt[i] = 0;
      chk("write flag", !ew, f0_out);
      chk("refresh flag", !(er && !cyc_internal), f1_out);
      chk("address out", {2'h0, cyc_addr}, {2'h0, bus_out});
      if (!cyc_internal) chk("clock out at T1", 1, pclk);
    end
    if (cyc_done === 1'b1) act = 1'b0;
    if (act) begin
      ncyc++;
      cnt[0] += !rd_n; cnt[1] += !fx_n; cnt[2] += !ln_n;
      cnt[3] += !da_n; cnt[4] += !db_n; cnt[5] += !dc_n;
      if (ew && fprev === 1'b0 && fx_n === 1'b1) chk("write data", cyc_wdata, pins);
    end
    fprev = fx_n;
  end

  initial begin
    seed = 47562; n_fail = 0; checks_done = 0; tmo = 0; act = 0; fprev = 1; run = 0; pcp = 0;
    n_ext = 0;
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010; hwdata = 0;
    cyc_req = 0; cyc_internal = 0; cyc_write = 0; cyc_refresh = 0; cyc_addr = 0;
    cyc_wdata = 0; rval = 0; wait_n = 0;
    cfg_ph = 12'hfff;
    cfg_st = `EMISG_STROBE_RST;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    run = 1'b1;
    rd_chk(32'(`EMISG_OFF_PHASE), 32'h00000fff);
    rd_chk(32'(`EMISG_OFF_STROBE), `EMISG_STROBE_RST);
    rd_chk(32'h00000040, 32'h00000000);
    cyc(1'b0, 1'b0, 1'b0, 4'h0);
    for (int i = 0; i < 30; i++) begin
      cfg_ph = 12'($random(seed));
      cfg_st = $random(seed) & 32'h1f1f1f1f;
      if (i == 0) cfg_st = cfg_st & 32'hffffe0e0;
      if (i == 1) cfg_st = cfg_st | 32'h1f1f1f00;
      bus(1'b1, 32'(`EMISG_OFF_PHASE), {20'h0, cfg_ph}, q);
      bus(1'b1, 32'(`EMISG_OFF_STROBE), cfg_st, q);
      rd_chk(32'(`EMISG_OFF_PHASE), {20'h0, cfg_ph});
      cyc(1'b0, 1'b0, 1'b0, 4'h0);
      cyc(1'b1, 1'b0, 1'b0, 4'($random(seed) & 3));
      cyc(1'b0, 1'b1, 1'b0, 4'($random(seed) & 3));
      cyc(1'b0, 1'b0, 1'b1, 4'h0);
    end
    bus(1'b1, 32'(`EMISG_OFF_CTRL), 32'h00000001, q);
    bus(1'b1, 32'(`EMISG_OFF_PHASE), 32'h00000000, q);
    rd_chk(32'(`EMISG_OFF_PHASE), {20'h0, cfg_ph});
    cyc(1'b0, 1'b0, 1'b0, 4'h0);
    rd_chk(32'(`EMISG_OFF_CTRL), 32'h00000001);
    rd_chk(32'(`EMISG_OFF_STATUS), 32'h1 << `EMISG_ST_LOCK);
    rd_chk(32'(`EMISG_OFF_COUNT), n_ext);
    final_report;
  end
endmodule
